// *** src/amr_ctrl.sv ***
// converter control: select register, channel/reference routing,
// result scaling, clamping, byte formatting and the read lock.
// assumes the converter core runs on clk_sys, pulses convStart when it
// samples and convDone with its signed sample when it finishes.
module amr_ctrl
#(
    parameter int SAMPLE_W = 16
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [amr_pkg::ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // converter core events
    input wire logic convStart,
    input wire logic convDone,
    input wire logic signed [SAMPLE_W-1:0] coreSample,
    // routing towards the analog front end
    output logic [2:0] posInput,
    output logic [2:0] negInput,
    output logic diffMode,
    output logic [1:0] gainSel,
    output logic bandgapSel,
    output logic groundSel,
    // reference switches
    output logic refExtPin,
    output logic refSupply,
    output logic refInternal,
    // status
    output logic convBusy,
    output logic doneFlag
);

    amr_pkg::amr_state_s st;
    amr_pkg::amr_state_s next_st;
    amr_pkg::amr_route_s route;
    logic selWr;
    logic statWr;
    logic rdLow;
    logic rdHigh;
    logic flagClr;
    logic resUpdate;
    logic signed [8:0] gainVal;
    logic signed [24:0] scaled;
    logic [9:0] convValue;
    logic [7:0] fmtHigh;
    logic [7:0] fmtLow;

    // channel code to input routing
    function automatic amr_pkg::amr_route_s decode(input logic [4:0] chan);
        amr_pkg::amr_route_s r;
        r = '0;
        casez (chan)
            5'b00???:
            begin
                r.pos = chan[2:0];
            end
            5'b01???:
            begin
                r.diff = 1'b1;
                r.pos = {1'b0, chan[2], chan[0]};
                r.neg = chan[2] ? amr_pkg::NEG_IN2 : amr_pkg::NEG_IN0;
                r.gain = chan[1] ? amr_pkg::GAIN_200X : amr_pkg::GAIN_10X;
            end
            5'b10???:
            begin
                r.diff = 1'b1;
                r.pos = chan[2:0];
                r.neg = amr_pkg::NEG_IN1;
                r.gain = amr_pkg::GAIN_1X;
            end
            amr_pkg::CHAN_BANDGAP:
            begin
                r.bandgap = 1'b1;
            end
            amr_pkg::CHAN_GROUND:
            begin
                r.ground = 1'b1;
            end
            default:
            begin
                r.diff = 1'b1;
                r.pos = chan[2:0];
                r.neg = amr_pkg::NEG_IN2;
                r.gain = amr_pkg::GAIN_1X;
            end
        endcase
        return r;
    endfunction : decode

    // register port decode
    assign selWr = regWrite && (regAddr == amr_pkg::ADDR_SELECT);
    assign statWr = regWrite && (regAddr == amr_pkg::ADDR_STATUS);
    assign flagClr = statWr && regWrData[amr_pkg::STAT_DONE_BIT];
    assign rdLow = regRead && (regAddr == amr_pkg::ADDR_RES_LOW);
    assign rdHigh = regRead && (regAddr == amr_pkg::ADDR_RES_HIGH);

    // a finished conversion lands only when no byte pair read is open
    assign resUpdate = (st.phase == amr_pkg::AMR_BUSY) && convDone && !st.locked;

    // gain of the applied channel
    always_comb
    begin
        case (st.gainSel)
            amr_pkg::GAIN_10X: gainVal = amr_pkg::GAIN_VAL_10;
            amr_pkg::GAIN_200X: gainVal = amr_pkg::GAIN_VAL_200;
            default: gainVal = amr_pkg::GAIN_VAL_1;
        endcase
    end

    // sample arrives in units of reference/1024 (single) or /512 (pair)
    assign scaled = 25'(coreSample) * 25'(gainVal);

    // clamp to the code range of the mode
    always_comb
    begin
        if (st.diffMode)
        begin
            if (scaled > amr_pkg::SAT_POS)
                convValue = amr_pkg::DIFF_MAX;
            else if (scaled < amr_pkg::SAT_NEG)
                convValue = amr_pkg::DIFF_MIN;
            else
                convValue = scaled[9:0]; // sign lands in bit 9
        end
        else
        begin
            if (scaled < 0)
                convValue = amr_pkg::SE_ZERO;
            else if (scaled > amr_pkg::SAT_SE_HI)
                convValue = amr_pkg::SE_FULL;
            else
                convValue = scaled[9:0];
        end
    end

    // byte layout follows the live adjust bit, not a captured copy
    amr_result_fmt u_fmt
    (
        .result(st.result),
        .leftAdjust(st.selReg[amr_pkg::ADJ_BIT]),
        .highByte(fmtHigh),
        .lowByte(fmtLow)
    );

    // next state
    always_comb
    begin
        next_st = st;

        // select register is plain read/write storage
        if (selWr)
            next_st.selReg = regWrData;

        // conversion phase
        case (st.phase)
            amr_pkg::AMR_IDLE:
            begin
                if (convStart)
                    next_st.phase = amr_pkg::AMR_BUSY;
            end
            amr_pkg::AMR_BUSY:
            begin
                if (convDone)
                    next_st.phase = amr_pkg::AMR_IDLE;
            end
            default:
            begin
                next_st.phase = amr_pkg::AMR_IDLE;
            end
        endcase
        next_st.busy = (next_st.phase == amr_pkg::AMR_BUSY);

        // selection reaches the front end only between conversions
        if (st.phase == amr_pkg::AMR_IDLE)
        begin
            next_st.appChan = st.selReg[amr_pkg::CHAN_MSB:0];
            if (st.selReg[amr_pkg::REF_MSB:amr_pkg::REF_LSB] != amr_pkg::REF_RSVD)
                next_st.appRef = st.selReg[amr_pkg::REF_MSB:amr_pkg::REF_LSB];
        end

        // registered routing outputs, decoded from the applied channel
        route = decode(next_st.appChan);
        next_st.posInput = route.pos;
        next_st.negInput = route.neg;
        next_st.diffMode = route.diff;
        next_st.gainSel = route.gain;
        next_st.bandgapSel = route.bandgap;
        next_st.groundSel = route.ground;

        // reference switches, internal source off unless chosen
        next_st.refExtPin = (next_st.appRef == amr_pkg::REF_EXT);
        next_st.refSupply = (next_st.appRef == amr_pkg::REF_SUPPLY);
        next_st.refInternal = (next_st.appRef == amr_pkg::REF_INT);

        // capture a finished result
        if (resUpdate)
            next_st.result = convValue;

        // done flag: write one clears, a completion in the same cycle wins
        if (flagClr)
            next_st.doneFlag = 1'b0;
        if (resUpdate)
            next_st.doneFlag = 1'b1;

        // read lock between low and high byte
        if (rdLow)
            next_st.locked = 1'b1;
        if (rdHigh)
            next_st.locked = 1'b0;

        // read data stands one cycle after the strobe
        next_st.rdData = 8'h00;
        if (regRead)
        begin
            case (regAddr)
                amr_pkg::ADDR_SELECT: next_st.rdData = st.selReg;
                amr_pkg::ADDR_RES_LOW: next_st.rdData = fmtLow;
                amr_pkg::ADDR_RES_HIGH: next_st.rdData = fmtHigh;
                amr_pkg::ADDR_STATUS:
                begin
                    next_st.rdData[amr_pkg::STAT_DONE_BIT] = st.doneFlag;
                    next_st.rdData[amr_pkg::STAT_BUSY_BIT] = st.busy;
                end
                default: next_st.rdData = 8'h00;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            st <= amr_pkg::AMR_STATE_RESET;
        else
            st <= next_st;
    end

    // outputs straight from the state record
    assign regRdData = st.rdData;
    assign posInput = st.posInput;
    assign negInput = st.negInput;
    assign diffMode = st.diffMode;
    assign gainSel = st.gainSel;
    assign bandgapSel = st.bandgapSel;
    assign groundSel = st.groundSel;
    assign refExtPin = st.refExtPin;
    assign refSupply = st.refSupply;
    assign refInternal = st.refInternal;
    assign convBusy = st.busy;
    assign doneFlag = st.doneFlag;

    // applied channel holds for the whole conversion
    a_chan_deferred: assert property (@(posedge clk_sys) disable iff (rst)
        (st.phase == amr_pkg::AMR_BUSY) |=> ($stable(st.appChan) && $stable(st.appRef)))
        else $error("selection changed during conversion");

    // reserved reference never reaches the switches
    a_ref_reserved: assert property (@(posedge clk_sys) disable iff (rst)
        (!st.refExtPin || !st.refInternal) && (st.appRef != amr_pkg::REF_RSVD))
        else $error("reserved or double reference applied");

    // internal reference switch stays on while a conversion uses it
    a_ref_internal: assert property (@(posedge clk_sys) disable iff (rst)
        (st.appRef == amr_pkg::REF_INT) && (st.phase == amr_pkg::AMR_BUSY)
        |=> st.refInternal && !st.refExtPin && !st.refSupply)
        else $error("internal reference not selected");

    // completion sets the flag and stores the clamped value
    a_done_update: assert property (@(posedge clk_sys) disable iff (rst)
        resUpdate |=> (st.doneFlag && (st.result == $past(convValue))))
        else $error("completion did not update result and flag");

    // a completion beats a same-cycle clear
    a_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
        (resUpdate && flagClr) |=> st.doneFlag)
        else $error("flag clear overrode completion");

    // clear alone drops the flag
    a_flag_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (flagClr && !resUpdate) |=> !st.doneFlag)
        else $error("flag not cleared");

    // result frozen from low read until high read
    a_lock_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (rdLow && !convDone) ##1 (!rdHigh)[*2] |=> $stable(st.result))
        else $error("result changed while byte pair read open");

    // differential overrange clamps at the most positive code
    a_diff_clamp: assert property (@(posedge clk_sys) disable iff (rst)
        (resUpdate && st.diffMode && (scaled > amr_pkg::SAT_POS))
        |=> (st.result == amr_pkg::DIFF_MAX))
        else $error("positive overrange not clamped");

    // negative single-ended input reads as zero
    a_se_floor: assert property (@(posedge clk_sys) disable iff (rst)
        (resUpdate && !st.diffMode && (scaled < 0)) |=> (st.result == amr_pkg::SE_ZERO))
        else $error("single-ended underrange not zero");

    // negative differential result carries the sign bit
    a_sign_bit: assert property (@(posedge clk_sys) disable iff (rst)
        (resUpdate && st.diffMode && (scaled < 0)) |=> st.result[9])
        else $error("sign bit missing");

    // high byte read shows the layout of the live adjust bit
    a_high_read: assert property (@(posedge clk_sys) disable iff (rst)
        rdHigh |=> (regRdData == ($past(st.selReg[amr_pkg::ADJ_BIT])
        ? $past(st.result[9:2]) : {6'h00, $past(st.result[9:8])})))
        else $error("high byte layout wrong");

    // busy follows a start within one cycle
    a_busy_start: assert property (@(posedge clk_sys) disable iff (rst)
        ((st.phase == amr_pkg::AMR_IDLE) && convStart) |=> convBusy)
        else $error("busy not raised on start");

    // ground code routes no input pair
    a_ground_route: assert property (@(posedge clk_sys) disable iff (rst)
        st.groundSel |-> (!st.diffMode && !st.bandgapSel))
        else $error("ground routing inconsistent");

    // low byte read shows the layout of the live adjust bit
    a_low_read: assert property (@(posedge clk_sys) disable iff (rst)
        rdLow |=> (regRdData == ($past(st.selReg[amr_pkg::ADJ_BIT])
        ? {$past(st.result[1:0]), 6'h00} : $past(st.result[7:0]))))
        else $error("low byte layout wrong");

    // a completion that meets an open byte pair read is dropped
    a_lock_drop: assert property (@(posedge clk_sys) disable iff (rst)
        (st.locked && convDone) |=> $stable(st.result))
        else $error("result updated while byte pair read open");

    // differential underrange clamps at the most negative code
    a_diff_floor: assert property (@(posedge clk_sys) disable iff (rst)
        (resUpdate && st.diffMode && (scaled < amr_pkg::SAT_NEG))
        |=> (st.result == amr_pkg::DIFF_MIN))
        else $error("negative overrange not clamped");

endmodule : amr_ctrl

// *** src/amr_pkg.sv ***
// package for the converter channel, reference and result-format control:
// register offsets, field positions, codes, limits and the state record.
// assumes one 50 MHz clock and a synchronous active-high reset.
// Contract
// - single-ended: ground 0x000, reference minus LSB 0x3FF
// - single-ended result is input times 1024 over reference
// - differential: difference times gain times 512 over reference
// - differential two's complement, clamped to 0x200..0x1FF
// - result bit 9 is the differential sign
// - completed result readable once done flag rises
// - select register: reference 7:6, adjust 5, channel 4:0
// - reference codes: external, supply, reserved, internal 2.56V
// - reference/channel writes apply after running conversion completes
// - adjust bit one left-adjusts, zero right-adjusts
// - adjust change alters result layout at once
// - codes 00000-00111 pick single-ended inputs 0-7
// - codes 01xxx pick pairs against input 0/2, 10x/200x
// - codes 10xxx against input 1, 11000-11101 against 2
// - code 11110 bandgap, code 11111 ground
// - byte placement of left and right adjusted results
// - low byte read freezes result until high byte read (a completion on the low read's own edge still lands)
// - done flag set when result registers are updated
package amr_pkg;

    // register offsets on the plain register port
    localparam int ADDR_W = 2;
    localparam logic [1:0] ADDR_SELECT = 2'h0;
    localparam logic [1:0] ADDR_RES_LOW = 2'h1;
    localparam logic [1:0] ADDR_RES_HIGH = 2'h2;
    localparam logic [1:0] ADDR_STATUS = 2'h3;

    // select register layout and reset value
    localparam int REF_MSB = 7;
    localparam int REF_LSB = 6;
    localparam int ADJ_BIT = 5;
    localparam int CHAN_MSB = 4;
    localparam logic [7:0] SELECT_RESET = 8'h00;

    // status register bits
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;

    // reference codes
    localparam logic [1:0] REF_EXT = 2'h0;
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [1:0] REF_RSVD = 2'h2;
    localparam logic [1:0] REF_INT = 2'h3;

    // gain codes and factors
    localparam logic [1:0] GAIN_1X = 2'h0;
    localparam logic [1:0] GAIN_10X = 2'h1;
    localparam logic [1:0] GAIN_200X = 2'h2;
    localparam logic signed [8:0] GAIN_VAL_1 = 9'sh001;
    localparam logic signed [8:0] GAIN_VAL_10 = 9'sh00A;
    localparam logic signed [8:0] GAIN_VAL_200 = 9'sh0C8;

    // fixed sources and fixed negative inputs
    localparam logic [4:0] CHAN_BANDGAP = 5'h1E;
    localparam logic [4:0] CHAN_GROUND = 5'h1F;
    localparam logic [2:0] NEG_IN0 = 3'h0;
    localparam logic [2:0] NEG_IN1 = 3'h1;
    localparam logic [2:0] NEG_IN2 = 3'h2;

    // result limits
    localparam logic [9:0] SE_ZERO = 10'h000;
    localparam logic [9:0] SE_FULL = 10'h3FF;
    localparam logic [9:0] DIFF_MAX = 10'h1FF;
    localparam logic [9:0] DIFF_MIN = 10'h200;
    localparam logic signed [24:0] SAT_SE_HI = 25'sh00003FF;
    localparam logic signed [24:0] SAT_POS = 25'sh00001FF;
    localparam logic signed [24:0] SAT_NEG = 25'sh1FFFE00;

    // conversion phase
    typedef enum logic {AMR_IDLE, AMR_BUSY} amr_phase_e;

    // routing of one channel code
    typedef struct packed {
        logic diff;
        logic [2:0] pos;
        logic [2:0] neg;
        logic [1:0] gain;
        logic bandgap;
        logic ground;
    } amr_route_s;

    // whole state of the control block
    typedef struct packed {
        amr_phase_e phase;
        logic busy;
        logic [7:0] selReg;
        logic [1:0] appRef;
        logic [4:0] appChan;
        logic [9:0] result;
        logic locked;
        logic doneFlag;
        logic [7:0] rdData;
        logic [2:0] posInput;
        logic [2:0] negInput;
        logic diffMode;
        logic [1:0] gainSel;
        logic bandgapSel;
        logic groundSel;
        logic refExtPin;
        logic refSupply;
        logic refInternal;
    } amr_state_s;

    localparam amr_state_s AMR_STATE_RESET = '0;

endpackage : amr_pkg

// *** src/amr_result_fmt.sv ***
// result byte formatter: places a 10-bit result into two bytes.
// assumes a stored result and the live adjust bit; purely combinational.
module amr_result_fmt
(
    // stored result and layout choice
    input wire logic [9:0] result,
    input wire logic leftAdjust,
    // formatted bytes
    output logic [7:0] highByte,
    output logic [7:0] lowByte
);

    // left: 9:2 high, 1:0 in low 7:6; right: 9:8 high 1:0, 7:0 low
    always_comb
    begin
        if (leftAdjust)
        begin
            highByte = result[9:2];
            lowByte = {result[1:0], 6'h00};
        end
        else
        begin
            highByte = {6'h00, result[9:8]};
            lowByte = result[7:0];
        end
    end

endmodule : amr_result_fmt

// *** tb/amr_core_model.sv ***
// converter core stand-in: starts a conversion on request, answers later.
// assumes requests arrive only while modelBusy is low, on clk_sys.
module amr_core_model
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // requests from the bench
    input wire logic reqGo,
    input wire logic signed [15:0] reqSample,
    input wire logic [7:0] reqLat,
    // core events towards the block
    output logic convStart,
    output logic convDone,
    output logic signed [15:0] coreSample,
    output logic modelBusy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;
    logic signed [15:0] held;

    // one conversion at a time; sample bus toggles whenever it is not valid, and holds 16'h5A5A in reset
    always @(posedge clk_sys)
    begin
        convStart <= 1'h0;
        convDone <= 1'h0;
        coreSample <= ~coreSample;
        if (rst)
        begin
            modelBusy <= 1'h0;
            cnt <= 8'h00;
            coreSample <= 16'h5A5A;
        end
        else if (!modelBusy && reqGo)
        begin
            convStart <= 1'h1;
            modelBusy <= 1'h1;
            cnt <= reqLat;
            held <= reqSample;
        end
        else if (modelBusy && cnt == 8'h00)
        begin
            convDone <= 1'h1;
            coreSample <= held;
            modelBusy <= 1'h0;
        end
        else if (modelBusy)
            cnt <= cnt - 8'h01;
    end
endmodule : amr_core_model

// *** tb/tb_adc_mux_ref_result_format.sv ***
// self-checking bench for the converter control block: register port,
// routing decode, scaling, layout, deferred selection and read lock.
// assumes the core stand-in amr_core_model on the same clock.
module tb_adc_mux_ref_result_format;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic [1:0] regAddr = 2'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'h0;
    logic regRead = 1'h0;
    logic reqGo = 1'h0;
    logic signed [15:0] reqSample = 16'h0000;
    logic [7:0] reqLat = 8'h01;
    logic [7:0] regRdData;
    logic convStart, convDone, modelBusy, diffMode, bandgapSel, groundSel;
    logic refExtPin, refSupply, refInternal, convBusy, doneFlag;
    logic signed [15:0] coreSample;
    logic [2:0] posInput, negInput;
    logic [1:0] gainSel;
    logic rdPend = 1'h0;
    logic [7:0] expQ[$];
    logic [9:0] lastRes;
    int n_errors = 0;
    int n_compared = 0;
    int seed = 35172;
    int cycles = 0;

    amr_ctrl #(.SAMPLE_W(16)) uut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .convStart(convStart), .convDone(convDone),
        .coreSample(coreSample), .posInput(posInput), .negInput(negInput),
        .diffMode(diffMode), .gainSel(gainSel), .bandgapSel(bandgapSel),
        .groundSel(groundSel), .refExtPin(refExtPin), .refSupply(refSupply),
        .refInternal(refInternal), .convBusy(convBusy), .doneFlag(doneFlag));
    amr_core_model core (.clk_sys(clk_sys), .rst(rst), .reqGo(reqGo),
        .reqSample(reqSample), .reqLat(reqLat), .convStart(convStart),
        .convDone(convDone), .coreSample(coreSample), .modelBusy(modelBusy));

    // 50 MHz clock
    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    // read data stand one cycle after the strobe; oldest note is compared
    always @(posedge clk_sys)
    begin
        if (rdPend)
            check("regRdData", regRdData, expQ.pop_front());
        rdPend <= regRead;
    end

    // hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            test_done();
        end
    end

    task automatic tick(input int n);
        regWrite <= 1'h0;
        regRead <= 1'h0;
        reqGo <= 1'h0;
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'h1;
        regRead <= 1'h0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        expQ.push_back(e);
        regAddr <= a;
        regRead <= 1'h1;
        regWrite <= 1'h0;
        @(posedge clk_sys);
    endtask : rd

    task automatic start(input int s, input logic [7:0] lat);
        reqSample <= s[15:0];
        reqLat <= lat;
        reqGo <= 1'h1;
        @(posedge clk_sys);
        tick(1);
    endtask : start

    task automatic waitDone();
        for (int k = 0; k < 300 && doneFlag !== 1'h1; k++)
            @(posedge clk_sys);
        check("doneFlag", doneFlag, 1'h1);
    endtask : waitDone

    // expected code: gain, then clamp to the single or differential range
    function automatic logic [9:0] scale(input logic [4:0] c, input int s);
        int v;
        v = s;
        if (c > 5'h07 && c < 5'h1E)
        begin
            if (c < 5'h10)
                v = s * (c[1] ? 200 : 10);
            return (v > 511) ? 10'h1FF : (v < -512) ? 10'h200 : v[9:0];
        end
        return (v > 1023) ? 10'h3FF : (v < 0) ? 10'h000 : v[9:0];
    endfunction : scale

    function automatic logic [15:0] fmt(input logic [9:0] r, input logic left);
        return left ? {r[9:2], r[1:0], 6'h00} : {6'h00, r};
    endfunction : fmt

    // one conversion: select, start, wait, read both bytes, clear the flag
    task automatic conv(input logic [7:0] sel, input int s, input logic [7:0] lat);
        logic [15:0] b;
        wr(amr_pkg::ADDR_SELECT, sel);
        tick(2);
        start(s, lat);
        waitDone();
        lastRes = scale(sel[4:0], s);
        b = fmt(lastRes, sel[5]);
        rd(amr_pkg::ADDR_STATUS, 8'h01);
        rd(amr_pkg::ADDR_RES_LOW, b[7:0]);
        rd(amr_pkg::ADDR_RES_HIGH, b[15:8]);
        wr(amr_pkg::ADDR_STATUS, 8'h01);
        tick(1);
        check("doneClear", doneFlag, 1'h0);
    endtask : conv

    initial
    begin
        logic [15:0] b;
        logic [7:0] v;
        logic [4:0] cd;
        logic [2:0] eP, eN;
        logic [1:0] eG;
        int k, eRef;
        static logic [7:0] cs [10] = '{8'h00, 8'h07, 8'h43, 8'hED, 8'hCD, 8'h0A, 8'h2E, 8'h5F,
            8'h00, 8'h00};
        static int cv [10] = '{0, 1023, 2000, -40, -40, 3, -3, 77, 0, 0};
        repeat (12) @(posedge clk_sys);
        rst <= 1'h0;
        tick(3);
        check("refExtPin", refExtPin, 1'h1);
        check("diffMode", diffMode, 1'h0);
        rd(amr_pkg::ADDR_SELECT, amr_pkg::SELECT_RESET);
        rd(amr_pkg::ADDR_STATUS, 8'h00);
        // select register holds what software writes
        for (int i = 0; i < 4; i++)
        begin
            k = $random(seed);
            v = k[7:0];
            if (v[7:6] == 2'h2)
                v[7:6] = 2'h3; // reserved reference avoided
            wr(amr_pkg::ADDR_SELECT, v);
            rd(amr_pkg::ADDR_SELECT, v);
        end
        // every reference code; the reserved one keeps the old switch
        eRef = 0;
        for (int r = 0; r < 4; r++)
        begin
            wr(amr_pkg::ADDR_SELECT, {r[1:0], 6'h00});
            tick(2);
            if (r != 2)
                eRef = r;
            check("refExtPin", refExtPin, eRef == 0);
            check("refSupply", refSupply, eRef == 1);
            check("refInternal", refInternal, eRef == 3);
        end
        // every channel code
        for (int c = 0; c < 32; c++)
        begin
            cd = c[4:0];
            wr(amr_pkg::ADDR_SELECT, {3'h0, cd});
            tick(2);
            eP = (cd[4:3] == 2'h1) ? {1'h0, cd[2], cd[0]} : cd[2:0];
            eN = (cd[4:3] == 2'h1) ? {1'h0, cd[2], 1'h0} : (cd[4:3] == 2'h2) ? 3'h1 : 3'h2;
            if (cd < 5'h08 || cd > 5'h1D)
                eN = 3'h0;
            eG = (cd[4:3] == 2'h1) ? (cd[1] ? 2'h2 : 2'h1) : 2'h0;
            if (cd < 5'h1E)
                check("posInput", posInput, eP);
            check("negInput", negInput, eN);
            check("gainSel", gainSel, eG);
            check("diffMode", diffMode, cd > 5'h07 && cd < 5'h1E);
            check("bandgapSel", bandgapSel, cd == amr_pkg::CHAN_BANDGAP);
            check("groundSel", groundSel, cd == amr_pkg::CHAN_GROUND);
        end
        // conversions over channels, clamps, layouts and latencies
        for (int i = 0; i < 10; i++)
        begin
            k = $random(seed);
            if (i > 7)
                cs[i] = {2'h1, k[5:0]};
            if (i > 7)
                cv[i] = k % 1200;
            conv(cs[i], cv[i], {3'h0, k[12:8]} + 8'h01);
        end
        // selection written mid-conversion waits; adjust acts at once
        wr(amr_pkg::ADDR_SELECT, 8'h41);
        tick(2);
        start(256, 8'h28);
        wr(amr_pkg::ADDR_SELECT, 8'hE6);
        tick(3);
        check("posInput", posInput, 3'h1);
        check("refSupply", refSupply, 1'h1);
        check("convBusy", convBusy, 1'h1);
        b = fmt(lastRes, 1'h1);
        rd(amr_pkg::ADDR_RES_HIGH, b[15:8]);
        rd(amr_pkg::ADDR_STATUS, 8'h02);
        tick(1);
        waitDone();
        tick(2);
        check("posInput", posInput, 3'h6);
        check("refInternal", refInternal, 1'h1);
        check("convBusy", convBusy, 1'h0);
        wr(amr_pkg::ADDR_STATUS, 8'h01);
        // low byte read holds the result until the high byte is read
        lastRes = 10'h100;
        b = fmt(lastRes, 1'h1);
        rd(amr_pkg::ADDR_RES_LOW, b[7:0]);
        tick(1);
        start(5, 8'h02);
        for (k = 0; k < 100 && modelBusy === 1'h1; k++)
            @(posedge clk_sys);
        tick(3);
        rd(amr_pkg::ADDR_STATUS, 8'h00);
        rd(amr_pkg::ADDR_RES_HIGH, b[15:8]);
        wr(amr_pkg::ADDR_RES_HIGH, 8'hFF);
        rd(amr_pkg::ADDR_RES_HIGH, b[15:8]);
        conv(8'h26, 5, 8'h03);
        // clear lands on the completion edge: the set wins; negative input floors
        start(-9, 8'h04);
        tick(4);
        wr(amr_pkg::ADDR_STATUS, 8'h01);
        tick(1);
        check("doneSetWins", doneFlag, 1'h1);
        rd(amr_pkg::ADDR_RES_LOW, 8'h00);
        rd(amr_pkg::ADDR_RES_HIGH, 8'h00);
        tick(3);
        test_done();
    end
endmodule : tb_adc_mux_ref_result_format
